// [verilog/tss_cfg.svh]
// Constants for the touch ADC serial sequencer
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH

`define TSS_CNT_W     5
`define TSS_CNT_IDLE  5'h00
`define TSS_CNT_ONE   5'h01
`define TSS_CNT_MAX   5'h1F
// Counter value ahead of the edge that takes each control bit
`define TSS_CAP_CH2   5'h01
`define TSS_CAP_CH1   5'h02
`define TSS_CAP_CH0   5'h03
`define TSS_CAP_RES   5'h04
`define TSS_CAP_REF   5'h05
`define TSS_CAP_PDH   5'h06
`define TSS_CAP_PDL   5'h07
// Falling-edge events, by counter value
`define TSS_CNT_PWRUP 5'h04
`define TSS_CNT_DRIVE 5'h06
`define TSS_CNT_WORD  5'h08
`define TSS_CNT_SAMPLE 5'h08
// Least counter value at which a new start bit is taken
`define TSS_GAP_12    5'h0F
`define TSS_GAP_8     5'h0B
`define TSS_LEFT_12   4'hC
`define TSS_LEFT_8    4'h8
`define TSS_LEFT_LAST 4'h1
`define TSS_CH_XPOS   3'h1
`define TSS_CH_YPOS   3'h5
// Reset values of the held control word
`define TSS_RST_CH    3'h0
`define TSS_RST_RES   1'h0
`define TSS_RST_REF   1'h0
`define TSS_RST_PDH   1'h1
`define TSS_RST_PDL   1'h0
// Synchroniser reset vector; chip select starts deselected
`define TSS_SYNC_RST  7'h20
`define TSS_NSYNC     7

`endif

// [verilog/tss_pkg.sv]
// Types of the touch ADC serial sequencer
`include "tss_cfg.svh"
`default_nettype none
package tss_pkg;
  typedef logic [`TSS_CNT_W-1:0] tss_cnt_t;
  typedef logic [11:0]           tss_sample_t;
  typedef logic [2:0]            tss_chan_t;
  typedef logic [3:0]            tss_left_t;
  typedef logic [6:0]            tss_word_t;
endpackage
`default_nettype wire

// [verilog/tss_sequencer.sv]
// Serial control and conversion sequencer of a touch-screen ADC
`include "tss_cfg.svh"
`default_nettype none
module tss_sequencer (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_serial_clock,
  input  wire logic            i_cs_n,
  input  wire logic            i_din,
  input  wire tss_pkg::tss_sample_t i_sample_data,
  input  wire logic            i_touch_detect,
  output var  logic            o_dout,
  output var  logic            o_dout_oe_n,
  output var  logic            o_busy,
  output var  logic            o_busy_oe_n,
  output var  logic            o_touch_alert_n_o,
  output var  logic            o_touch_alert_n_oe_n,
  output var  logic            o_powered,
  output var  logic            o_track_hold,
  output var  tss_pkg::tss_chan_t o_channel_sel,
  output var  logic            o_res_8bit,
  output var  logic            o_ref_mode_sel,
  output var  logic            o_power_field_hi,
  output var  logic            o_power_field_lo,
  output var  logic            o_x_pos_drv,
  output var  logic            o_x_neg_drv,
  output var  logic            o_y_pos_drv,
  output var  logic            o_y_neg_drv
);

  // ---------------- Link domain (serial clock) ----------------
  // Chip select clears link state, all but the word snapshot, at once; a stopped clock cannot wait for an edge
  tss_pkg::tss_cnt_t    ctl_cnt_r;
  tss_pkg::tss_chan_t   channel_sel_r;
  logic                 res_8bit_r;
  logic                 ref_mode_sel_r;
  logic                 pd_hi_stage_r;
  tss_pkg::tss_word_t   word_snap_r;
  logic                 word_tgl_r;
  tss_pkg::tss_sample_t sample_m_r;
  tss_pkg::tss_sample_t sample_s_r;
  tss_pkg::tss_sample_t shift_r;
  tss_pkg::tss_left_t   conv_left_r;
  logic                 lk_active_r;
  logic                 lk_penoff_r;
  logic                 lk_drive_r;
  logic                 lk_hold_r;
  logic                 start_ok;
  logic                 in_word;
  logic                 conv_end;

  always_comb begin
    start_ok = i_din && ((ctl_cnt_r == `TSS_CNT_IDLE) ||
               (res_8bit_r ? (ctl_cnt_r >= `TSS_GAP_8)
                           : (ctl_cnt_r >= `TSS_GAP_12)));
    in_word  = (ctl_cnt_r != `TSS_CNT_IDLE) && (ctl_cnt_r <= `TSS_CNT_WORD);
    conv_end = (conv_left_r == `TSS_LEFT_LAST);
  end

  // Frame position counter, saturating so an idle gap keeps starts open
  always_ff @(posedge i_serial_clock or posedge i_cs_n) begin
    if (i_cs_n) begin
      ctl_cnt_r <= `TSS_CNT_IDLE;
    end else if (start_ok) begin
      ctl_cnt_r <= `TSS_CNT_ONE;
    end else if (ctl_cnt_r != `TSS_CNT_IDLE && ctl_cnt_r != `TSS_CNT_MAX) begin
      ctl_cnt_r <= ctl_cnt_r + `TSS_CNT_ONE;
    end
  end

  // Control fields, each updated as its bit arrives
  always_ff @(posedge i_serial_clock or posedge i_cs_n) begin
    if (i_cs_n) begin
      channel_sel_r  <= `TSS_RST_CH;
      res_8bit_r     <= `TSS_RST_RES;
      ref_mode_sel_r <= `TSS_RST_REF;
      pd_hi_stage_r  <= `TSS_RST_PDH;
    end else begin
      case (ctl_cnt_r)
        `TSS_CAP_CH2: channel_sel_r[2] <= i_din;
        `TSS_CAP_CH1: channel_sel_r[1] <= i_din;
        `TSS_CAP_CH0: channel_sel_r[0] <= i_din;
        `TSS_CAP_RES: res_8bit_r       <= i_din;
        `TSS_CAP_REF: ref_mode_sel_r   <= i_din;
        `TSS_CAP_PDH: pd_hi_stage_r    <= i_din;
        default: ;
      endcase
    end
  end

  // Word crosses as snapshot plus toggle; snapshot holds eleven serial clocks or more
  always_ff @(posedge i_serial_clock) begin
    if (ctl_cnt_r == `TSS_CAP_PDL) begin
      word_snap_r <= {channel_sel_r, res_8bit_r, ref_mode_sel_r,
                      pd_hi_stage_r, i_din};
    end
  end

  always_ff @(posedge i_serial_clock or posedge i_cs_n) begin
    if (i_cs_n) begin
      word_tgl_r <= 1'h0;
    end else if (ctl_cnt_r == `TSS_CAP_PDL) begin
      word_tgl_r <= ~word_tgl_r;
    end
  end

  // Front-end result is asynchronous to the link
  always_ff @(posedge i_serial_clock or posedge i_cs_n) begin
    if (i_cs_n) begin
      sample_m_r <= 12'h000;
      sample_s_r <= 12'h000;
    end else begin
      sample_m_r <= i_sample_data;
      sample_s_r <= sample_m_r;
    end
  end

  always_ff @(negedge i_serial_clock or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_busy <= 1'h0;
    end else begin
      o_busy <= (ctl_cnt_r == `TSS_CNT_SAMPLE);
    end
  end

  // Result shifter; 8-bit results use the top bits and pad with zeros
  always_ff @(negedge i_serial_clock or posedge i_cs_n) begin
    if (i_cs_n) begin
      conv_left_r <= 4'h0;
      shift_r     <= 12'h000;
      o_dout      <= 1'h0;
    end else if (ctl_cnt_r == `TSS_CNT_SAMPLE) begin
      conv_left_r <= res_8bit_r ? `TSS_LEFT_8 : `TSS_LEFT_12;
      shift_r     <= sample_s_r;
      o_dout      <= 1'h0;
    end else if (conv_left_r != 4'h0) begin
      o_dout      <= shift_r[11];
      shift_r     <= {shift_r[10:0], 1'h0};
      conv_left_r <= conv_left_r - 4'h1;
    end else begin
      o_dout      <= 1'h0;
    end
  end

  // Phase levels; a new word's set wins over the old conversion's end
  always_ff @(negedge i_serial_clock or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_active_r <= 1'h0;
      lk_penoff_r <= 1'h0;
      lk_drive_r  <= 1'h0;
      lk_hold_r   <= 1'h0;
    end else begin
      if (ctl_cnt_r == `TSS_CNT_PWRUP) begin
        lk_active_r <= 1'h1;
      end else if (conv_end && !in_word) begin
        lk_active_r <= 1'h0;
      end
      if (ctl_cnt_r == `TSS_CNT_ONE) begin
        lk_penoff_r <= 1'h1;
      end else if (conv_end && !in_word) begin
        lk_penoff_r <= 1'h0;
      end
      if (ctl_cnt_r == `TSS_CNT_DRIVE) begin
        lk_drive_r <= 1'h1;
      end else if (ctl_cnt_r == `TSS_CNT_SAMPLE && ref_mode_sel_r) begin
        lk_drive_r <= 1'h0;
      end else if (conv_end) begin
        lk_drive_r <= 1'h0;
      end
      if (ctl_cnt_r == `TSS_CNT_SAMPLE) begin
        lk_hold_r <= 1'h1;
      end else if (conv_end) begin
        lk_hold_r <= 1'h0;
      end
    end
  end

  // ---------------- System domain (i_clk) ----------------
  localparam logic [`TSS_NSYNC-1:0] SYNC_RST = `TSS_SYNC_RST;
  localparam int IX_HOLD  = 0;
  localparam int IX_DRIVE = 1;
  localparam int IX_ACT   = 2;
  localparam int IX_PEN   = 3;
  localparam int IX_TGL   = 4;
  localparam int IX_CS    = 5;
  localparam int IX_TOUCH = 6;

  logic [`TSS_NSYNC-1:0] sync_in;
  logic [`TSS_NSYNC-1:0] sync_s;
  logic                  tgl_seen_r;
  logic                  cfg_change_r;
  logic                  kept_r;
  logic                  word_evt;
  logic                  drv_on;

  assign sync_in = {i_touch_detect, i_cs_n, word_tgl_r, lk_penoff_r,
                    lk_active_r, lk_drive_r, lk_hold_r};

  // Levels only; the multi-bit word crosses by the toggle above
  for (genvar g = 0; g < `TSS_NSYNC; g++) begin : g_sync
    logic meta_r;
    logic sync_r;
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        meta_r <= SYNC_RST[g];
        sync_r <= SYNC_RST[g];
      end else begin
        meta_r <= sync_in[g];
        sync_r <= meta_r;
      end
    end
    assign sync_s[g] = sync_r;
  end

  assign word_evt = sync_s[IX_TGL] != tgl_seen_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tgl_seen_r <= 1'h0;
    end else begin
      tgl_seen_r <= sync_s[IX_TGL];
    end
  end

  // Held control word; survives chip-select frames
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_channel_sel    <= `TSS_RST_CH;
      o_res_8bit       <= `TSS_RST_RES;
      o_ref_mode_sel   <= `TSS_RST_REF;
      o_power_field_hi <= `TSS_RST_PDH;
      o_power_field_lo <= `TSS_RST_PDL;
      cfg_change_r     <= 1'h0;
    end else begin
      cfg_change_r <= 1'h0;
      if (word_evt) begin
        {o_channel_sel, o_res_8bit, o_ref_mode_sel,
         o_power_field_hi, o_power_field_lo} <= word_snap_r;
        cfg_change_r <= (word_snap_r[6:4] != o_channel_sel) ||
                        (word_snap_r[2] != o_ref_mode_sel) ||
                        (word_snap_r[1:0] != {o_power_field_hi, o_power_field_lo});
      end
    end
  end

  // Mode 11 keeps the drivers on between conversions
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      kept_r <= 1'h0;
    end else if (cfg_change_r) begin
      kept_r <= 1'h0;
    end else if (sync_s[IX_DRIVE] && o_power_field_hi && o_power_field_lo) begin
      kept_r <= 1'h1;
    end
  end

  assign drv_on = sync_s[IX_DRIVE] || kept_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_x_pos_drv <= 1'h0;
      o_x_neg_drv <= 1'h0;
      o_y_pos_drv <= 1'h0;
      o_y_neg_drv <= 1'h0;
    end else begin
      o_y_pos_drv <= drv_on && (o_channel_sel == `TSS_CH_XPOS);
      o_x_pos_drv <= drv_on && (o_channel_sel == `TSS_CH_YPOS);
      o_x_neg_drv <= drv_on && (o_channel_sel == `TSS_CH_YPOS);
      o_y_neg_drv <= (drv_on && (o_channel_sel == `TSS_CH_XPOS)) ||
                     (!drv_on && !sync_s[IX_PEN] && !o_power_field_lo);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_powered    <= 1'h1;
      o_track_hold <= 1'h0;
    end else begin
      o_powered    <= sync_s[IX_ACT] || o_power_field_hi;
      o_track_hold <= sync_s[IX_HOLD];
    end
  end

  // Open-drain alert: pulled low only for a touch while enabled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_touch_alert_n_o    <= 1'h0;
      o_touch_alert_n_oe_n <= 1'h1;
    end else begin
      o_touch_alert_n_o    <= 1'h0;
      o_touch_alert_n_oe_n <= !(sync_s[IX_TOUCH] && !sync_s[IX_PEN] &&
                                !o_power_field_lo);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dout_oe_n <= 1'h1;
      o_busy_oe_n <= 1'h1;
    end else begin
      o_dout_oe_n <= sync_s[IX_CS];
      o_busy_oe_n <= sync_s[IX_CS];
    end
  end

  // ---------------- Checks ----------------
  busy_one_edge_a: assert property (@(negedge i_serial_clock) disable iff (i_cs_n)
    (ctl_cnt_r == `TSS_CNT_SAMPLE) |=> o_busy ##1 !o_busy)
    else $error("busy not a one-cycle pulse at sampling");
  dout_ctrl_low_a: assert property (@(negedge i_serial_clock) disable iff (i_cs_n)
    (conv_left_r == 4'h0 && in_word) |=> !o_dout)
    else $error("data output not low in control cycles");
  conv_length_a: assert property (@(negedge i_serial_clock) disable iff (i_cs_n)
    (ctl_cnt_r == `TSS_CNT_SAMPLE && !res_8bit_r) |=>
      (conv_left_r == 4'hC) ##12 (conv_left_r == 4'h0))
    else $error("12-bit conversion length wrong");
  // Last result bit still stands one edge after the end; zeros follow it
  hold_release_a: assert property (@(negedge i_serial_clock) disable iff (i_cs_n)
    (conv_end && ctl_cnt_r != `TSS_CNT_SAMPLE) |=> !lk_hold_r ##1 !o_dout)
    else $error("hold or data not released after last bit");
  start_gap12_a: assert property (@(posedge i_serial_clock) disable iff (i_cs_n)
    (!res_8bit_r && ctl_cnt_r >= `TSS_CNT_ONE && ctl_cnt_r < `TSS_GAP_12)
      |=> ctl_cnt_r != `TSS_CNT_ONE)
    else $error("start taken too early in 12-bit mode");
  start_gap8_a: assert property (@(posedge i_serial_clock) disable iff (i_cs_n)
    (res_8bit_r && ctl_cnt_r >= `TSS_CNT_ONE && ctl_cnt_r < `TSS_GAP_8)
      |=> ctl_cnt_r != `TSS_CNT_ONE)
    else $error("start taken too early in 8-bit mode");
  power_active_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sync_s[IX_ACT] |=> o_powered)
    else $error("not powered while converting");
  power_always_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_power_field_hi ##1 o_power_field_hi |-> o_powered)
    else $error("permanent power mode lost power");
  alert_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (sync_s[IX_PEN] || o_power_field_lo) |=> o_touch_alert_n_oe_n)
    else $error("touch alert driven while disabled");
  float_cs_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sync_s[IX_CS] |=> o_dout_oe_n && o_busy_oe_n)
    else $error("outputs driven with chip select high");
endmodule
`default_nettype wire

// [bench/tss_host_model.sv]
// Host serial master model for the touch ADC sequencer link
`default_nettype none
module tss_host_model (
  output var  logic o_serial_clock,
  output var  logic o_cs_n,
  output var  logic o_din,
  input  wire logic i_dout,
  input  wire logic i_busy,
  input  wire logic i_dout_oe_n,
  input  wire logic i_powered,
  input  wire logic i_track_hold,
  input  wire logic i_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 24;

  initial begin
    o_serial_clock = 1'b0;
    o_cs_n         = 1'b1;
    o_din          = 1'b0;
  end

  // Clock stands still low outside frames; din set while clock is low
  task automatic frame(input logic [47:0] pat, input int n, input int gap,
                       output logic [47:0] dcap, output logic [47:0] bcap,
                       output logic [3:0] mid);
    dcap = '0;
    bcap = '0;
    mid  = '0;
    o_cs_n = 1'b0;
    #HALF;
    for (int e = 1; e <= n; e++) begin
      o_din = pat[48-e];
      #HALF;
      o_serial_clock = 1'b1;
      dcap[48-e] = i_dout;
      bcap[48-e] = i_busy;
      if (e == 12) mid = {i_dout_oe_n, i_powered, i_track_hold, i_drive};
      #HALF;
      o_serial_clock = 1'b0;
      if (gap != 0 && e % 8 == 0) #gap;
    end
    #HALF;
    o_cs_n = 1'b1;
    // Released line must not keep showing its last value
    o_din = ~o_din;
  endtask
endmodule
`default_nettype wire

// [bench/touch_adc_serial_sequencer_tb.sv]
// Self-checking bench for the touch ADC serial sequencer
`default_nettype none
module touch_adc_serial_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  w;
    logic [11:0] s;
    logic        y_neg;
    logic        x_pos;
    logic        pwr;
    logic        alert;
  } tss_row_t;
  localparam tss_row_t ROWS [5] = '{
    '{8'h90, 12'hA5C, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'hD5, 12'h3C9, 1'b0, 1'b0, 1'b0, 1'b1},
    '{8'h9A, 12'hF0F, 1'b1, 1'b0, 1'b1, 1'b0},
    '{8'hD3, 12'h6B1, 1'b0, 1'b1, 1'b1, 1'b1},
    '{8'h93, 12'h2E7, 1'b1, 1'b0, 1'b1, 1'b1}
  };
  logic                i_clk;
  logic                i_rst;
  logic                i_touch_detect;
  tss_pkg::tss_sample_t i_sample_data;
  logic                sclk, cs_n, din;
  logic                dout, dout_oe_n, busy, busy_oe_n, alert_o, alert_oe_n;
  logic                powered, hold, res8, refm, pdh, pdl;
  logic                xp, xn, yp, yn;
  tss_pkg::tss_chan_t  chan;
  logic [47:0]         dcap, bcap;
  logic [3:0]          mid;
  int                  fails, total_checks;

  tss_sequencer i_tss_sequencer (
    .i_clk(i_clk), .i_rst(i_rst), .i_serial_clock(sclk), .i_cs_n(cs_n), .i_din(din),
    .i_sample_data(i_sample_data), .i_touch_detect(i_touch_detect), .o_dout(dout),
    .o_dout_oe_n(dout_oe_n), .o_busy(busy), .o_busy_oe_n(busy_oe_n),
    .o_touch_alert_n_o(alert_o), .o_touch_alert_n_oe_n(alert_oe_n), .o_powered(powered),
    .o_track_hold(hold), .o_channel_sel(chan), .o_res_8bit(res8), .o_ref_mode_sel(refm),
    .o_power_field_hi(pdh), .o_power_field_lo(pdl), .o_x_pos_drv(xp), .o_x_neg_drv(xn),
    .o_y_pos_drv(yp), .o_y_neg_drv(yn)
  );
  tss_host_model i_tss_host_model (
    .o_serial_clock(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout), .i_busy(busy),
    .i_dout_oe_n(dout_oe_n), .i_powered(powered), .i_track_hold(hold), .i_drive(xp | yp)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Result bits of a word whose start bit is on rising edge k
  function automatic logic [47:0] stream(input logic [7:0] w, input logic [11:0] s, input int k);
    logic [47:0] v;
    v = '0;
    for (int i = 0; i < (w[3] ? 8 : 12); i++) begin
      v[48-(k+9+i)] = s[11-i];
    end
    return v;
  endfunction

  task automatic run(input logic [47:0] pat, input int n, input int gap);
    @(negedge i_clk);
    i_tss_host_model.frame(pat, n, gap, dcap, bcap, mid);
    repeat (6) @(negedge i_clk);
  endtask

  function automatic logic [6:0] word_out();
    return {chan, res8, refm, pdh, pdl};
  endfunction

  initial begin
    #200000;
    fails++;
    results();
  end

  initial begin
    fails = 0;
    total_checks = 0;
    i_rst = 1'b1;
    i_touch_detect = 1'b1;
    i_sample_data = 12'h000;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    for (int r = 0; r < 5; r++) begin
      i_sample_data = ROWS[r].s;
      run({ROWS[r].w, 40'h0}, 24, (r % 2) * 300);
      check(dcap, stream(ROWS[r].w, ROWS[r].s, 1), "dout frame");
      check(bcap, 48'h1 << 39, "busy");
      check(mid, {3'b011, ~ROWS[r].w[2]}, "mid frame");
      check(word_out(), ROWS[r].w[6:0], "word");
      check({yn, xp, xn, powered, alert_oe_n, dout_oe_n, alert_o},
            {ROWS[r].y_neg, ROWS[r].x_pos, ROWS[r].x_pos, ROWS[r].pwr, ROWS[r].alert, 2'h2},
            "after frame");
    end
    // Last row is mode 11 on channel 001: Y drivers stay on, X drivers off
    check({yp, xn}, 2'h2, "kept drivers");
    // Second reset in mid-run
    i_rst = 1'b1;
    repeat (10) @(negedge i_clk);
    check({word_out(), powered, hold, dout_oe_n}, {7'h02, 3'b101}, "reset");
    i_rst = 1'b0;
    // No start bit: nothing written, nothing converted
    run(48'h0, 24, 0);
    check({dcap, bcap}, 96'h0, "no start");
    check(word_out(), 7'h02, "no start word");
    // Start bit one edge too early is ignored
    i_sample_data = 12'hC3A;
    run({8'h90, 40'h0} | (48'h1 << 33), 40, 0);
    check(dcap, stream(8'h90, 12'hC3A, 1), "early dout");
    check(bcap, 48'h1 << 39, "early busy");
    // Fifteen clocks per cycle, 12-bit
    run({8'h90, 40'h0} | ({8'h94, 40'h0} >> 15), 39, 0);
    check(dcap, stream(8'h90, 12'hC3A, 1) | stream(8'h94, 12'hC3A, 16), "ovl12");
    check(bcap, (48'h1 << 39) | (48'h1 << 24), "ovl12 busy");
    check(word_out(), 7'h14, "ovl12 word");
    // Eleven clocks per cycle, 8-bit
    i_sample_data = 12'h5E1;
    run({8'h9A, 40'h0} | ({8'h98, 40'h0} >> 11), 35, 0);
    check(dcap, stream(8'h9A, 12'h5E1, 1) | stream(8'h98, 12'h5E1, 12), "ovl8");
    check(bcap, (48'h1 << 39) | (48'h1 << 28), "ovl8 busy");
    // Chip select raised in mid-conversion
    run({8'h90, 40'h0}, 14, 0);
    check(mid[1], 1'b1, "abort hold");
    check({dout_oe_n, busy_oe_n, hold, busy, dout}, 5'b11000, "abort");
    // Mode 00 held: alert follows the touch input between conversions
    check(alert_oe_n, 1'h0, "alert touched");
    i_touch_detect = 1'h0;
    repeat (4) @(negedge i_clk);
    check(alert_oe_n, 1'h1, "alert released");
    results();
  end
endmodule
`default_nettype wire
